// [rtl/sync_regs_pkg.sv]
// constants, register map and carrier types of the sync status and power control slice
package sync_regs_pkg;
	// clock and timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int SEP_TICK_HZ = 5_000_000;
	localparam int SEP_DIV = CLOCK_HZ / SEP_TICK_HZ;
	localparam int HS_TIMEOUT_US = 100;
	localparam int HS_TIMEOUT_CYCLES = (CLOCK_HZ / 1_000_000) * HS_TIMEOUT_US;
	localparam int VS_TIMEOUT_MS = 100;
	localparam int VS_TIMEOUT_CYCLES = (CLOCK_HZ / 1_000) * VS_TIMEOUT_MS;
	localparam int HS_RUN_W = 12;
	localparam int VS_RUN_W = 22;
	localparam int LINE_W = 12;
	localparam int PIXEL_W = 48;
	localparam int DCLK_W = 2;

	// register offsets
	localparam logic [7:0] POWER_CTRL_ADDR = 8'h0F;
	localparam logic [7:0] SLICER_CLAMP_ADDR = 8'h10;
	localparam logic [7:0] SEP_THRESH_ADDR = 8'h11;
	localparam logic [7:0] PRE_WINDOW_ADDR = 8'h12;
	localparam logic [7:0] POST_WINDOW_ADDR = 8'h13;
	localparam logic [7:0] STATUS_ADDR = 8'h14;

	// field positions
	localparam int POWER_BIT = 1;
	localparam int SLICER_LSB = 3;
	localparam int SLICER_MSB = 7;
	localparam int RED_CLAMP_BIT = 2;
	localparam int BLUE_CLAMP_BIT = 1;
	localparam int ST_HS_ACT = 7;
	localparam int ST_AHS = 6;
	localparam int ST_HS_POL = 5;
	localparam int ST_VS_ACT = 4;
	localparam int ST_AVS = 3;
	localparam int ST_VS_POL = 2;
	localparam int ST_GS_ACT = 1;
	localparam int ST_FW_POL = 0;

	// reset values
	localparam logic POWER_RESET = 1'h1;
	localparam logic [4:0] SLICER_RESET = 5'h0F;
	localparam logic CLAMP_RESET = 1'h0;
	localparam logic [7:0] SEP_THRESH_RESET = 8'h20;
	localparam logic [7:0] PRE_WINDOW_RESET = 8'h00;
	localparam logic [7:0] POST_WINDOW_RESET = 8'h00;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} bus_req_t;

	// detector results
	typedef struct packed {
		logic active;
		logic polarity;
		logic level;
		logic lead;
	} sync_stat_t;
endpackage : sync_regs_pkg

// [rtl/sync_activity_detector.sv]
// activity, polarity and leading edge detector for one asynchronous sync pin
module sync_activity_detector #(
	parameter int TIMEOUT = 2500,
	parameter int RUN_W = 12
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// pin and result
	input wire logic pin_i,
	output sync_regs_pkg::sync_stat_t stat_o
);
	localparam int IDLE_W = $clog2(TIMEOUT + 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(TIMEOUT - 1);

	logic meta_reg;
	logic level_reg;
	logic last_reg;
	logic [IDLE_W-1:0] idle_reg;
	logic active_reg;
	logic [RUN_W-1:0] run_reg;
	logic [RUN_W-1:0] high_len_reg;
	logic [RUN_W-1:0] low_len_reg;
	logic polarity_reg;
	logic edge_seen;

	////////////////////////////////////////////////////////////////
	// two flops before any logic, a third for edge finding
	// kept out of reset so a pin idling high gives no false edge after reset
	always_ff @(posedge clock_i) begin
		meta_reg <= pin_i;
		level_reg <= meta_reg;
		last_reg <= level_reg;
	end

	assign edge_seen = level_reg ^ last_reg;

	////////////////////////////////////////////////////////////////
	// activity: a static pin, high or low, times out
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			idle_reg <= '0;
			active_reg <= 1'h0;
		end else if (edge_seen) begin
			idle_reg <= '0;
			active_reg <= 1'h1;
		end else if (idle_reg == IDLE_LAST) begin
			active_reg <= 1'h0;
		end else begin
			idle_reg <= idle_reg + 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// polarity: the shorter level is the pulse
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			run_reg <= '0;
			high_len_reg <= '0;
			low_len_reg <= '0;
			polarity_reg <= 1'h0;
		end else begin
			if (edge_seen) begin
				run_reg <= '0;
				if (last_reg) begin
					high_len_reg <= run_reg;
				end else begin
					low_len_reg <= run_reg;
				end
			end else if (run_reg != '1) begin
				run_reg <= run_reg + 1'h1;
			end
			polarity_reg <= high_len_reg < low_len_reg;
		end
	end

	assign stat_o = '{active: active_reg, polarity: polarity_reg, level: level_reg,
		lead: edge_seen && (level_reg == polarity_reg)};
endmodule : sync_activity_detector

// [rtl/sync_status_power_control_regs.sv]
// power, slicer, clamp, separator, freewheel and sync status registers
// What this block does
// - power bit 0 powers down, 1 runs
// - power-down tri-states sync, clocks, 48 data
// - green sync slicer output always keeps driving
// - references, sync logic, registers run during power-down
// - five-bit slicer threshold, 10 mV steps, default 15
// - red clamp select ground or midscale
// - blue clamp select ground or midscale
// - separator counts 5 MHz ticks to threshold
// - freewheel starts pre-window lines before vsync
// - freewheel held post-window lines after vsync
// - status bit 7 shows hsync activity
// - active horizontal source from detects or override
// - status bit 5 shows hsync polarity
// - status bit 4 shows vsync activity
// - active vertical source from detect or override
// - status bit 2 shows vsync polarity
// - status bit 1 shows green sync activity
// - status bit 0 shows freewheel input polarity
module sync_status_power_control_regs #(
	parameter int VS_TIMEOUT = sync_regs_pkg::VS_TIMEOUT_CYCLES,
	parameter int HS_TIMEOUT = sync_regs_pkg::HS_TIMEOUT_CYCLES,
	parameter int LINE_W = sync_regs_pkg::LINE_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [7:0] rdata_o,
	// source selects from the neighbouring register
	input wire logic h_override_i,
	input wire logic h_select_i,
	input wire logic v_override_i,
	input wire logic v_select_i,
	// sync pins
	input wire logic hsync_i,
	input wire logic green_embedded_sync_i,
	input wire logic vsync_i,
	input wire logic freewheel_i,
	// datapath from the converters
	input wire logic [sync_regs_pkg::PIXEL_W-1:0] pixel_data_i,
	input wire logic [sync_regs_pkg::DCLK_W-1:0] pixel_data_clock_i,
	// three-state outputs
	output logic [sync_regs_pkg::PIXEL_W-1:0] pixel_data_o,
	output logic [sync_regs_pkg::PIXEL_W-1:0] pixel_data_oe_o,
	output logic [sync_regs_pkg::DCLK_W-1:0] pixel_data_clock_out_o,
	output logic [sync_regs_pkg::DCLK_W-1:0] pixel_data_clock_out_oe_o,
	output logic horizontal_sync_out_o,
	output logic horizontal_sync_out_oe_o,
	output logic vertical_sync_out_o,
	output logic vertical_sync_out_oe_o,
	output logic green_sync_slicer_out_o,
	output logic green_sync_slicer_out_oe_o,
	// analog and pll controls
	output logic low_power_o,
	output logic [4:0] slicer_threshold_o,
	output logic red_clamp_mid_o,
	output logic blue_clamp_mid_o,
	output logic pll_freewheel_o,
	output logic active_horizontal_source_o,
	output logic active_vertical_source_o
);
	sync_regs_pkg::bus_req_t req;
	sync_regs_pkg::sync_stat_t hs;
	sync_regs_pkg::sync_stat_t gs;
	sync_regs_pkg::sync_stat_t vs;
	sync_regs_pkg::sync_stat_t fw;

	logic low_power_select_reg;
	logic [4:0] slicer_reg;
	logic red_clamp_reg;
	logic blue_clamp_reg;
	logic [7:0] sep_thresh_reg;
	logic [7:0] pre_reg;
	logic [7:0] post_reg;
	logic [7:0] rdata_reg;
	logic [7:0] status;
	logic active_horizontal_source;
	logic active_vertical_source;
	logic [2:0] tick_div_reg;
	logic sep_tick;
	logic [7:0] sep_cnt_reg;
	logic sep_reg;
	logic h_lead;
	logic v_act;
	logic v_act_last_reg;
	logic [LINE_W-1:0] line_cnt_reg;
	logic [LINE_W-1:0] period_reg;
	logic [LINE_W-1:0] lines_left;
	logic pre_act;
	logic [7:0] post_cnt_reg;
	logic [sync_regs_pkg::PIXEL_W-1:0] pixel_reg;
	logic [sync_regs_pkg::DCLK_W-1:0] dclk_reg;
	logic h_out_reg;
	logic v_out_reg;

	assign req = '{addr: addr_i, wdata: wdata_i, write: write_i, read: read_i};

	////////////////////////////////////////////////////////////////
	// detectors keep running in power-down
	// sync detection live
	sync_activity_detector #(.TIMEOUT(HS_TIMEOUT), .RUN_W(sync_regs_pkg::HS_RUN_W)) hs_det (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(hsync_i),
		.stat_o(hs)
	);
	sync_activity_detector #(.TIMEOUT(HS_TIMEOUT), .RUN_W(sync_regs_pkg::HS_RUN_W)) gs_det (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(green_embedded_sync_i),
		.stat_o(gs)
	);
	sync_activity_detector #(.TIMEOUT(VS_TIMEOUT), .RUN_W(sync_regs_pkg::VS_RUN_W)) vs_det (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(vsync_i),
		.stat_o(vs)
	);
	sync_activity_detector #(.TIMEOUT(VS_TIMEOUT), .RUN_W(sync_regs_pkg::VS_RUN_W)) fw_det (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.pin_i(freewheel_i),
		.stat_o(fw)
	);

	////////////////////////////////////////////////////////////////
	// writable registers
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			low_power_select_reg <= sync_regs_pkg::POWER_RESET;
			slicer_reg <= sync_regs_pkg::SLICER_RESET;
			red_clamp_reg <= sync_regs_pkg::CLAMP_RESET;
			blue_clamp_reg <= sync_regs_pkg::CLAMP_RESET;
			sep_thresh_reg <= sync_regs_pkg::SEP_THRESH_RESET;
			pre_reg <= sync_regs_pkg::PRE_WINDOW_RESET;
			post_reg <= sync_regs_pkg::POST_WINDOW_RESET;
		end else if (req.write) begin
			case (req.addr)
				sync_regs_pkg::POWER_CTRL_ADDR: begin
					low_power_select_reg <= req.wdata[sync_regs_pkg::POWER_BIT];
				end
				// slicer threshold, red clamp, blue clamp
				sync_regs_pkg::SLICER_CLAMP_ADDR: begin
					slicer_reg <= req.wdata[sync_regs_pkg::SLICER_MSB:sync_regs_pkg::SLICER_LSB];
					red_clamp_reg <= req.wdata[sync_regs_pkg::RED_CLAMP_BIT];
					blue_clamp_reg <= req.wdata[sync_regs_pkg::BLUE_CLAMP_BIT];
				end
				sync_regs_pkg::SEP_THRESH_ADDR: begin
					sep_thresh_reg <= req.wdata;
				end
				sync_regs_pkg::PRE_WINDOW_ADDR: begin
					pre_reg <= req.wdata;
				end
				sync_regs_pkg::POST_WINDOW_ADDR: begin
					post_reg <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	assign low_power_o = !low_power_select_reg;
	assign slicer_threshold_o = slicer_reg;
	assign red_clamp_mid_o = red_clamp_reg;
	assign blue_clamp_mid_o = blue_clamp_reg;

	////////////////////////////////////////////////////////////////
	// source selection
	// horizontal source
	assign active_horizontal_source = (h_override_i || (hs.active == gs.active)) ? h_select_i : gs.active;
	assign active_vertical_source = v_override_i ? v_select_i : !vs.active;
	assign active_horizontal_source_o = active_horizontal_source;
	assign active_vertical_source_o = active_vertical_source;

	// hsync activity, both sources, hsync polarity, vsync activity, vsync polarity, green activity, freewheel polarity
	always_comb begin
		status = 8'h00;
		status[sync_regs_pkg::ST_HS_ACT] = hs.active;
		status[sync_regs_pkg::ST_AHS] = active_horizontal_source;
		status[sync_regs_pkg::ST_HS_POL] = hs.polarity;
		status[sync_regs_pkg::ST_VS_ACT] = vs.active;
		status[sync_regs_pkg::ST_AVS] = active_vertical_source;
		status[sync_regs_pkg::ST_VS_POL] = vs.polarity;
		status[sync_regs_pkg::ST_GS_ACT] = gs.active;
		status[sync_regs_pkg::ST_FW_POL] = fw.polarity;
	end

	////////////////////////////////////////////////////////////////
	// read port, data valid only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else if (!req.read) begin
			rdata_reg <= 8'h00;
		end else begin
			case (req.addr)
				sync_regs_pkg::POWER_CTRL_ADDR: rdata_reg <= 8'(low_power_select_reg) << sync_regs_pkg::POWER_BIT;
				sync_regs_pkg::SLICER_CLAMP_ADDR: rdata_reg <= {slicer_reg, red_clamp_reg, blue_clamp_reg, 1'h0};
				sync_regs_pkg::SEP_THRESH_ADDR: rdata_reg <= sep_thresh_reg;
				sync_regs_pkg::PRE_WINDOW_ADDR: rdata_reg <= pre_reg;
				sync_regs_pkg::POST_WINDOW_ADDR: rdata_reg <= post_reg;
				sync_regs_pkg::STATUS_ADDR: rdata_reg <= status;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////
	// sync separator on a 5 MHz tick from the system clock
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tick_div_reg <= 3'h0;
		end else if (tick_div_reg == 3'(sync_regs_pkg::SEP_DIV - 1)) begin
			tick_div_reg <= 3'h0;
		end else begin
			tick_div_reg <= tick_div_reg + 3'h1;
		end
	end

	assign sep_tick = tick_div_reg == 3'h0;

	// horizontal pulses end before the count runs out, so only vertical flips the output
	// separator count
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sep_cnt_reg <= 8'h00;
			sep_reg <= 1'h0;
		end else if (gs.level == sep_reg) begin
			sep_cnt_reg <= 8'h00;
		end else if (sep_tick) begin
			if (sep_cnt_reg + 8'h01 >= sep_thresh_reg) begin
				sep_reg <= gs.level;
				sep_cnt_reg <= 8'h00;
			end else begin
				sep_cnt_reg <= sep_cnt_reg + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// freewheel windows in horizontal periods
	assign h_lead = active_horizontal_source ? gs.lead : hs.lead;
	assign v_act = active_vertical_source ? (sep_reg == gs.polarity) : (vs.level == vs.polarity);

	// period learnt from the last frame; the pre window predicts the next vertical edge
	// pre window
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			v_act_last_reg <= 1'h0;
			line_cnt_reg <= '0;
			period_reg <= '0;
		end else begin
			v_act_last_reg <= v_act;
			if (v_act && !v_act_last_reg) begin
				period_reg <= line_cnt_reg;
				line_cnt_reg <= '0;
			end else if (h_lead && line_cnt_reg != '1) begin
				line_cnt_reg <= line_cnt_reg + 1'h1;
			end
		end
	end

	assign lines_left = period_reg - line_cnt_reg;
	assign pre_act = (pre_reg != 8'h00) && (period_reg != '0) && (line_cnt_reg <= period_reg)
		&& (lines_left < LINE_W'(pre_reg));

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			post_cnt_reg <= 8'h00;
		end else if (v_act) begin
			post_cnt_reg <= post_reg;
		end else if (h_lead && post_cnt_reg != 8'h00) begin
			post_cnt_reg <= post_cnt_reg - 8'h01;
		end
	end

	assign pll_freewheel_o = v_act || pre_act || (post_cnt_reg != 8'h00);

	////////////////////////////////////////////////////////////////
	// output stage
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pixel_reg <= '0;
			dclk_reg <= '0;
			h_out_reg <= 1'h0;
			v_out_reg <= 1'h0;
		end else begin
			pixel_reg <= pixel_data_i;
			dclk_reg <= pixel_data_clock_i;
			h_out_reg <= active_horizontal_source ? gs.level : hs.level;
			v_out_reg <= v_act;
		end
	end

	assign pixel_data_o = pixel_reg;
	assign pixel_data_clock_out_o = dclk_reg;
	assign horizontal_sync_out_o = h_out_reg;
	assign vertical_sync_out_o = v_out_reg;
	assign pixel_data_oe_o = {sync_regs_pkg::PIXEL_W{low_power_select_reg}};
	assign pixel_data_clock_out_oe_o = {sync_regs_pkg::DCLK_W{low_power_select_reg}};
	assign horizontal_sync_out_oe_o = low_power_select_reg;
	assign vertical_sync_out_oe_o = low_power_select_reg;
	assign green_sync_slicer_out_o = gs.level;
	assign green_sync_slicer_out_oe_o = 1'h1;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_power_write: assert property (req.write && req.addr == sync_regs_pkg::POWER_CTRL_ADDR
		|=> low_power_o == !$past(wdata_i[1])) else $error("power bit not taken");
	a_pd_tristate: assert property (low_power_o |-> pixel_data_oe_o == '0 && pixel_data_clock_out_oe_o == '0
		&& !horizontal_sync_out_oe_o && !vertical_sync_out_oe_o) else $error("output driven in power-down");
	a_green_drive: assert property (green_sync_slicer_out_oe_o && green_sync_slicer_out_o == $past(green_embedded_sync_i, 2))
		else $error("green output released");
	a_pd_detect: assert property (low_power_o && read_i && addr_i == sync_regs_pkg::STATUS_ADDR
		|=> rdata_o[7] == $past(hs.active)) else $error("status frozen in power-down");
	a_slicer_field: assert property (req.write && req.addr == sync_regs_pkg::SLICER_CLAMP_ADDR
		|=> slicer_threshold_o == $past(wdata_i[7:3]) && red_clamp_mid_o == $past(wdata_i[2])
		&& blue_clamp_mid_o == $past(wdata_i[1])) else $error("slicer or clamp field wrong");
	a_sep_toggle: assert property ($changed(sep_reg) |-> $past(sep_tick) && $past(gs.level) != $past(sep_reg)
		&& $past(sep_cnt_reg) + 8'h01 >= $past(sep_thresh_reg)) else $error("separator flipped early");
	a_pre_window: assert property ($rose(v_act) && $stable(pre_reg) && pre_reg != 8'h00 && period_reg != '0
		&& line_cnt_reg == period_reg |-> $past(pll_freewheel_o)) else $error("pre window missing");
	a_post_hold: assert property ($fell(v_act) && post_reg != 8'h00 && !$past(h_lead)
		|-> pll_freewheel_o) else $error("post window missing");
	a_ahs_override: assert property (h_override_i |-> active_horizontal_source_o == h_select_i)
		else $error("horizontal override ignored");
	a_ahs_auto: assert property (!h_override_i && hs.active && !gs.active |-> !active_horizontal_source_o)
		else $error("horizontal auto select wrong");
	a_avs_auto: assert property (!v_override_i |-> active_vertical_source_o == !vs.active)
		else $error("vertical auto select wrong");
	a_status_read: assert property (read_i && addr_i == sync_regs_pkg::STATUS_ADDR
		|=> rdata_o == {$past(hs.active), $past(active_horizontal_source), $past(hs.polarity), $past(vs.active), $past(active_vertical_source),
		$past(vs.polarity), $past(gs.active), $past(fw.polarity)}) else $error("status read wrong");

	c_power_down: cover property (low_power_o ##1 !low_power_o);
	c_sep_flip: cover property ($changed(sep_reg));
	c_freewheel: cover property ($rose(pll_freewheel_o) && !v_act);
endmodule : sync_status_power_control_regs

// [dv/sync_source_model.sv]
// graphics source model driving the hsync, green sync, vsync and freewheel pins
module sync_source_model (
	// clock
	input wire logic clock_i,
	// per pin controls: bit 0 hsync, 1 green sync, 2 vsync, 3 freewheel
	input wire logic [3:0] run_i,
	input wire logic [3:0] pos_i,
	// sync pins
	output logic hsync_o,
	output logic green_o,
	output logic vsync_o,
	output logic freewheel_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned tick = 0;
	logic line_pulse;
	logic frame_pulse;
	always_ff @(posedge clock_i) begin
		tick <= tick + 1;
	end
	// lines of 100 cycles and frames of exactly ten lines keep both pulses phase locked
	assign line_pulse = (tick % 100) < 8;
	assign frame_pulse = (tick % 1000) < 40;
	// a stopped source sits at its inactive level, so the pin reads static
	assign hsync_o = ~(pos_i[0] ^ (run_i[0] & line_pulse));
	assign green_o = ~(pos_i[1] ^ (run_i[1] & line_pulse));
	assign vsync_o = ~(pos_i[2] ^ (run_i[2] & frame_pulse));
	assign freewheel_o = ~(pos_i[3] ^ (run_i[3] & frame_pulse));
endmodule : sync_source_model

// [dv/sync_status_power_control_regs_test.sv]
// self-checking bench of the sync status and power control register slice
module sync_status_power_control_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic write_i = 1'b0;
	logic read_i = 1'b0;
	logic [7:0] rdata_o;
	logic h_override_i = 1'b0;
	logic h_select_i = 1'b0;
	logic v_override_i = 1'b0;
	logic v_select_i = 1'b0;
	logic [3:0] run = 4'h0;
	logic [3:0] pos = 4'hF;
	logic hsync_i, green_embedded_sync_i, vsync_i, freewheel_i;
	logic [sync_regs_pkg::PIXEL_W-1:0] pixel_data_i = 48'hA5A5_5A5A_0FF0;
	logic [sync_regs_pkg::DCLK_W-1:0] pixel_data_clock_i = 2'h1;
	logic [sync_regs_pkg::PIXEL_W-1:0] pixel_data_o, pixel_data_oe_o;
	logic [sync_regs_pkg::DCLK_W-1:0] pixel_data_clock_out_o, pixel_data_clock_out_oe_o;
	logic horizontal_sync_out_o, horizontal_sync_out_oe_o, vertical_sync_out_o, vertical_sync_out_oe_o;
	logic green_sync_slicer_out_o, green_sync_slicer_out_oe_o, low_power_o, red_clamp_mid_o, blue_clamp_mid_o;
	logic [4:0] slicer_threshold_o;
	logic pll_freewheel_o, active_horizontal_source_o, active_vertical_source_o;
	logic [7:0] wtab [4] = '{8'hFF, 8'h04, 8'h02, 8'h08};
	int bad_count = 0;
	int compares = 0;
	int n0;
	int n1;
	////////////////////////////////////////////////////////////////////////////////
	// short timeouts keep the run brief; the source periods stay well inside them
	sync_status_power_control_regs #(.VS_TIMEOUT(2000), .HS_TIMEOUT(200)) uut (
		.clock_i, .rst_n_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
		.h_override_i, .h_select_i, .v_override_i, .v_select_i,
		.hsync_i, .green_embedded_sync_i, .vsync_i, .freewheel_i, .pixel_data_i, .pixel_data_clock_i,
		.pixel_data_o, .pixel_data_oe_o, .pixel_data_clock_out_o, .pixel_data_clock_out_oe_o,
		.horizontal_sync_out_o, .horizontal_sync_out_oe_o, .vertical_sync_out_o, .vertical_sync_out_oe_o,
		.green_sync_slicer_out_o, .green_sync_slicer_out_oe_o, .low_power_o, .slicer_threshold_o,
		.red_clamp_mid_o, .blue_clamp_mid_o, .pll_freewheel_o, .active_horizontal_source_o,
		.active_vertical_source_o
	);
	sync_source_model source (
		.clock_i(clock_i), .run_i(run), .pos_i(pos), .hsync_o(hsync_i),
		.green_o(green_embedded_sync_i), .vsync_o(vsync_i), .freewheel_o(freewheel_i)
	);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cycles
	// a gap cycle after each strobe keeps a strobe from being assigned twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		write_i <= 1'b1;
		@(posedge clock_i);
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr_i <= a;
		read_i <= 1'b1;
		@(posedge clock_i);
		read_i <= 1'b0;
		#1;
		`CHECK(rdata_o, exp)
		@(posedge clock_i);
	endtask : rd
	// counts freewheel cycles over exactly one frame, so the phase does not matter
	task automatic frame(output int n);
		n = 0;
		repeat (1000) begin
			@(negedge clock_i);
			if (pll_freewheel_o === 1'b1) n++;
		end
		@(posedge clock_i);
	endtask : frame
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (60000) @(posedge clock_i);
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cycles(20);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rd(8'h0F, 8'h02);
		rd(8'h10, 8'h78);
		rd(8'h11, 8'h20);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		rd(8'h20, 8'h00);
		rd(8'h14, 8'h08);
		`CHECK({low_power_o, slicer_threshold_o, red_clamp_mid_o, blue_clamp_mid_o}, 8'h3C)
		`CHECK({pixel_data_oe_o, pixel_data_clock_out_oe_o, horizontal_sync_out_oe_o, vertical_sync_out_oe_o}, {52{1'b1}})
		`CHECK(pixel_data_o, pixel_data_i)
		`CHECK({horizontal_sync_out_o, pixel_data_clock_out_o}, 3'h1)
		// power-down and back
		wr(8'h0F, 8'h00);
		`CHECK(low_power_o, 1'b1)
		`CHECK({pixel_data_oe_o, pixel_data_clock_out_oe_o, horizontal_sync_out_oe_o, vertical_sync_out_oe_o}, 52'h0)
		`CHECK(green_sync_slicer_out_oe_o, 1'b1)
		wr(8'h12, 8'h3C);
		rd(8'h12, 8'h3C);
		wr(8'h0F, 8'hFF);
		rd(8'h0F, 8'h02);
		`CHECK({low_power_o, pixel_data_oe_o, horizontal_sync_out_oe_o}, {1'b0, {49{1'b1}}})
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, wtab[i]);
			rd(8'h10, wtab[i] & 8'hFE);
			`CHECK({slicer_threshold_o, red_clamp_mid_o, blue_clamp_mid_o}, wtab[i][7:1])
		end
		wr(8'h11, 8'hA5);
		rd(8'h11, 8'hA5);
		wr(8'h13, 8'h5A);
		rd(8'h13, 8'h5A);
		wr(8'h12, 8'h00);
		wr(8'h13, 8'h00);
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h08);
		// hsync alone, positive pulses
		run <= 4'h1;
		cycles(400);
		rd(8'h14, 8'hA8);
		// every source running, positive pulses, green preferred
		run <= 4'hF;
		h_select_i <= 1'b1;
		cycles(2500);
		rd(8'h14, 8'hF7);
		`CHECK({active_horizontal_source_o, active_vertical_source_o}, 2'h2)
		wr(8'h11, 8'h20);
		frame(n0);
		wr(8'h13, 8'h03);
		cycles(1000);
		frame(n1);
		`CHECK((n1 - n0) inside {[180:320]}, 1'b1)
		wr(8'h13, 8'h00);
		wr(8'h12, 8'h02);
		cycles(2000);
		frame(n1);
		`CHECK((n1 - n0) inside {[150:250]}, 1'b1)
		wr(8'h12, 8'h00);
		// separator path: line pulses must not pass a high threshold
		v_override_i <= 1'b1;
		v_select_i <= 1'b1;
		cycles(1000);
		frame(n1);
		`CHECK(n1, 0)
		wr(8'h11, 8'h01);
		cycles(1000);
		frame(n1);
		`CHECK(n1 > 20, 1'b1)
		wr(8'h11, 8'h20);
		v_override_i <= 1'b0;
		v_select_i <= 1'b0;
		// negative pulses on every pin
		pos <= 4'h0;
		cycles(2500);
		rd(8'h14, 8'hD2);
		v_override_i <= 1'b1;
		v_select_i <= 1'b1;
		rd(8'h14, 8'hDA);
		h_override_i <= 1'b1;
		h_select_i <= 1'b0;
		rd(8'h14, 8'h9A);
		// hsync stops while powered down
		wr(8'h0F, 8'h00);
		run <= 4'hE;
		cycles(400);
		rd(8'h14, 8'h1A);
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h1A);
		h_override_i <= 1'b0;
		rd(8'h14, 8'h5A);
		`CHECK({active_horizontal_source_o, active_vertical_source_o}, 2'h3)
		complete_run();
	end
endmodule : sync_status_power_control_regs_test
